// ### rtl/tdf_pkg.sv
package tdf_pkg;

    // ******************************************************************
    // Descriptor layout in host memory (byte offsets).
    // ******************************************************************
    localparam logic [7:0]  DESC_NEXT_OFS      = 8'h00;
    localparam logic [7:0]  DESC_CTRL_OFS      = 8'h08;
    localparam logic [7:0]  DESC_FRAG_OFS      = 8'h10;
    localparam logic [7:0]  DESC_FRAG_LAST_OFS = 8'h80;
    localparam logic [7:0]  DESC_ENTRY_BYTES   = 8'h08;
    localparam int          ADDR_W             = 40;
    localparam int          FRAG_MAX           = 15;

    // ******************************************************************
    // Control word field positions.
    // ******************************************************************
    localparam int          CW_ID_LSB          = 0;
    localparam int          CW_ID_MSB          = 15;
    localparam int          CW_ROUND_LSB       = 16;
    localparam int          CW_ROUND_MSB       = 17;
    localparam int          CW_TCP_BIT         = 18;
    localparam int          CW_UDP_BIT         = 19;
    localparam int          CW_IP_BIT          = 20;
    localparam int          CW_CRC_INH_BIT     = 21;
    localparam int          CW_FRAG_LSB        = 24;
    localparam int          CW_FRAG_MSB        = 27;
    localparam int          CW_OWNER_BIT       = 31;

    // ******************************************************************
    // AHB-Lite register map and encodings.
    // ******************************************************************
    localparam logic [7:0]  REG_CTRL           = 8'h00;
    localparam logic [7:0]  REG_HEAD_LO        = 8'h04;
    localparam logic [7:0]  REG_HEAD_HI        = 8'h08;
    localparam logic [7:0]  REG_STATUS         = 8'h0c;
    localparam logic [7:0]  REG_CTRL_WORD      = 8'h10;
    localparam logic [7:0]  REG_CUR_LO         = 8'h14;
    localparam logic [7:0]  REG_COUNT          = 8'h18;
    localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
    localparam logic [31:0] RESET_WORD         = 32'h0000_0000;

    typedef struct packed {
        logic        valid;
        logic [15:0] frame_id;
        logic [1:0]  length_round_select;
        logic        tcp_csum_offload;
        logic        udp_csum_offload;
        logic        ip_csum_offload;
        logic        crc_append;
        logic [3:0]  fragment_total;
    } tdf_frame_t;

    typedef struct packed {
        logic              req;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } tdf_mreq_t;

endpackage

// ### rtl/tdf_ahb_slave.sv
`timescale 1ns/10ps
module tdf_ahb_slave
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic [31:0] rd_data_i,
    output logic             wr_en_o,
    output logic [7:0]       wr_addr_o,
    output logic [31:0]      wr_data_o,
    output logic [7:0]       rd_addr_o,
    output logic [31:0]      hrdata_o
);
    import tdf_pkg::*;

    // ******************************************************************
    // Zero-wait slave: address phase captured, data phase completes at once.
    // ******************************************************************
    logic       wr_pend_ff;
    logic [7:0] addr_ff;
    wire        take = hsel_i & hready_i & htrans_i[1];

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
        end
        else if (hready_i)
        begin
            wr_pend_ff <= take & hwrite_i;
            addr_ff    <= take ? haddr_i : addr_ff;
        end
    end

    assign wr_en_o   = wr_pend_ff;
    assign wr_addr_o = addr_ff;
    assign wr_data_o = hwdata_i;
    assign rd_addr_o = haddr_i;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            hrdata_o <= RESET_WORD;
        else if (take & ~hwrite_i)
            hrdata_o <= rd_data_i;
    end
endmodule

// ### rtl/tdf_fetch.sv
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
// Function
// [RL1] Host aligns descriptors on 64-bit boundaries.
// [RL2] Layout: next 0x00, control 0x08, fragments 0x10.
// [RL3] Next address uses low 40 bits only.
// [RL4] Zero next pointer ends the chain.
// [RL5] Host zeros upper pointer bits; device ignores them.
// [RL6] Control bits 15:0 carry frame identifier.
// [RL7] Bits 17:16 select length rounding boundary.
// [RL8] Bit 18 requests TCP checksum insertion.
// [RL9] Bit 19 requests UDP checksum insertion.
// [RL10] Bit 20 requests IP checksum insertion.
// [RL11] Host sets offload bits only for matching frames.
// [RL12] Offload forces device-appended frame check sequence.
// [RL13] Bit 31 ownership: fetch on zero, set when done.
// [RL14] Bits 27:24 fragment count; zero means no data.
// [RL15] Bit 21 inhibits CRC append, except underrun.
// [RL16] Bus master walks descriptor chain in order.
module tdf_fetch
(
    input  wire logic                clk_sys_i,
    input  wire logic                reset_n_i,
    input  wire logic                hsel_i,
    input  wire logic [7:0]          haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    output logic [31:0]              hrdata_o,
    output tdf_pkg::tdf_mreq_t       mreq_o,
    input  wire logic                m_ack_i,
    input  wire logic [31:0]         m_rdata_i,
    input  wire logic                tx_underrun_i,
    output tdf_pkg::tdf_frame_t      frame_o,
    output logic [39:0]              frag_addr_o,
    output logic [31:0]              frag_len_o,
    output logic                     frag_valid_o,
    output logic                     crc_force_bad_o
);
    import tdf_pkg::*;

    // ******************************************************************
    // State and registers.
    // ******************************************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_NEXT_LO, ST_NEXT_HI, ST_CTRL, ST_FRAG_LO, ST_FRAG_HI,
        ST_FRAG_OUT, ST_DONE_WR, ST_STEP
    } tdf_state_t;

    tdf_state_t        state_ff;
    tdf_state_t        nxt_state;
    logic              enable_ff;
    logic              kick_ff;
    logic [ADDR_W-1:0] head_ff;
    logic [ADDR_W-1:0] cur_ff;
    logic [ADDR_W-1:0] next_ff;
    logic [31:0]       ctrl_ff;
    logic [31:0]       frag_lo_ff;
    logic [3:0]        frag_idx_ff;
    logic [31:0]       desc_count_ff;
    logic              req_ff;
    logic              wr_ff;
    logic [ADDR_W-1:0] maddr_ff;
    logic [31:0]       mwdata_ff;
    logic              fvalid_ff;
    logic              bad_ff;
    tdf_frame_t        frame_ff;

    logic              wr_en;
    logic [7:0]        wr_addr;
    logic [31:0]       wr_data;
    logic [7:0]        rd_addr;
    logic [31:0]       rd_data;

    tdf_ahb_slave u_slave
    (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .hsel_i    (hsel_i),
        .haddr_i   (haddr_i),
        .htrans_i  (htrans_i),
        .hwrite_i  (hwrite_i),
        .hready_i  (1'b1),
        .hwdata_i  (hwdata_i),
        .rd_data_i (rd_data),
        .wr_en_o   (wr_en),
        .wr_addr_o (wr_addr),
        .wr_data_o (wr_data),
        .rd_addr_o (rd_addr),
        .hrdata_o  (hrdata_o)
    );

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // ******************************************************************
    // Register decode.
    // ******************************************************************
    function automatic logic [ADDR_W-1:0] entry_addr(input logic [ADDR_W-1:0] base, input logic [7:0] ofs);
        entry_addr = base + {{(ADDR_W-8){1'b0}}, ofs};
    endfunction

    wire [3:0]  fcount   = ctrl_ff[CW_FRAG_MSB:CW_FRAG_LSB];
    wire        any_csum = ctrl_ff[CW_TCP_BIT] | ctrl_ff[CW_UDP_BIT] | ctrl_ff[CW_IP_BIT];
    wire        busy     = (state_ff != ST_IDLE);
    wire        mdone    = req_ff & m_ack_i;

    assign rd_data = (rd_addr == REG_CTRL)      ? {31'h0, enable_ff} :
                     (rd_addr == REG_HEAD_LO)   ? head_ff[31:0] :
                     (rd_addr == REG_HEAD_HI)   ? {24'h0, head_ff[39:32]} :
                     (rd_addr == REG_STATUS)    ? {30'h0, kick_ff, busy} :
                     (rd_addr == REG_CTRL_WORD) ? ctrl_ff :
                     (rd_addr == REG_CUR_LO)    ? cur_ff[31:0] :
                     (rd_addr == REG_COUNT)     ? desc_count_ff : RESET_WORD;

    // ******************************************************************
    // Chain walker next state.
    // ******************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:     if (enable_ff && kick_ff && head_ff != '0) nxt_state = ST_CTRL;
            ST_CTRL:     if (mdone) nxt_state = m_rdata_i[CW_OWNER_BIT] ? ST_IDLE : ST_NEXT_LO; // RL13
            ST_NEXT_LO:  if (mdone) nxt_state = ST_NEXT_HI;
            ST_NEXT_HI:  if (mdone) nxt_state = (fcount == 4'h0) ? ST_DONE_WR : ST_FRAG_LO; // RL14
            ST_FRAG_LO:  if (mdone) nxt_state = ST_FRAG_HI;
            ST_FRAG_HI:  if (mdone) nxt_state = ST_FRAG_OUT;
            // The index has already stepped past the entry just handed out.
            ST_FRAG_OUT: nxt_state = (frag_idx_ff >= fcount) ? ST_DONE_WR : ST_FRAG_LO;
            ST_DONE_WR:  if (mdone) nxt_state = ST_STEP;
            ST_STEP:     nxt_state = (next_ff == '0) ? ST_IDLE : ST_CTRL; // RL4
            default:     nxt_state = ST_IDLE;
        endcase
    end

    wire [7:0] frag_ofs = DESC_FRAG_OFS + {frag_idx_ff, 3'b000};
    wire       issue    = (nxt_state != state_ff) || (state_ff == ST_IDLE);

    // ******************************************************************
    // Sequential logic.
    // ******************************************************************
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_ff      <= ST_IDLE;
            enable_ff     <= 1'b0;
            kick_ff       <= 1'b0;
            head_ff       <= '0;
            cur_ff        <= '0;
            next_ff       <= '0;
            ctrl_ff       <= RESET_WORD;
            frag_lo_ff    <= RESET_WORD;
            frag_idx_ff   <= 4'h0;
            desc_count_ff <= RESET_WORD;
            req_ff        <= 1'b0;
            wr_ff         <= 1'b0;
            maddr_ff      <= '0;
            mwdata_ff     <= RESET_WORD;
            fvalid_ff     <= 1'b0;
            bad_ff        <= 1'b0;
            frame_ff      <= '0;
            frag_addr_o   <= '0;
            frag_len_o    <= RESET_WORD;
        end
        else
        begin
            state_ff  <= nxt_state;
            fvalid_ff <= (state_ff == ST_FRAG_OUT);
            bad_ff    <= tx_underrun_i & frame_ff.valid; // RL15
            if (wr_en && wr_addr == REG_CTRL)
                enable_ff <= wr_data[0];
            if (wr_en && wr_addr == REG_HEAD_LO)
                head_ff[31:0] <= {wr_data[31:3], 3'b000}; // RL1
            if (wr_en && wr_addr == REG_HEAD_HI)
                head_ff[39:32] <= wr_data[7:0];
            // A kick that lands in the cycle the walker leaves ST_IDLE is kept: set wins.
            if (wr_en && wr_addr == REG_STATUS && wr_data[1])
                kick_ff <= 1'b1;
            else if (state_ff == ST_IDLE && nxt_state == ST_CTRL)
                kick_ff <= 1'b0;
            if (state_ff == ST_IDLE && nxt_state == ST_CTRL)
                cur_ff <= head_ff;
            if (state_ff == ST_STEP && next_ff != '0)
            begin
                cur_ff  <= next_ff; // RL16
                head_ff <= next_ff;
            end
            if (state_ff == ST_STEP && next_ff == '0)
                head_ff <= cur_ff;
            if (mdone && state_ff == ST_CTRL)
                ctrl_ff <= m_rdata_i;
            if (mdone && state_ff == ST_NEXT_LO)
                next_ff[31:0] <= m_rdata_i;
            if (mdone && state_ff == ST_NEXT_HI)
                next_ff[39:32] <= m_rdata_i[7:0]; // RL3 RL5
            if (mdone && state_ff == ST_FRAG_LO)
                frag_lo_ff <= m_rdata_i;
            if (mdone && state_ff == ST_FRAG_HI)
            begin
                frag_addr_o <= {m_rdata_i[7:0], frag_lo_ff};
                frag_len_o  <= {16'h0, m_rdata_i[31:16]};
            end
            if (state_ff == ST_NEXT_LO && mdone)
                frag_idx_ff <= 4'h0;
            else if (state_ff == ST_FRAG_HI && mdone)
                frag_idx_ff <= frag_idx_ff + 4'h1;
            if (mdone && state_ff == ST_NEXT_HI)
            begin
                frame_ff.valid               <= 1'b1;
                frame_ff.frame_id            <= ctrl_ff[CW_ID_MSB:CW_ID_LSB]; // RL6
                frame_ff.length_round_select <= ctrl_ff[CW_ROUND_MSB:CW_ROUND_LSB]; // RL7
                frame_ff.tcp_csum_offload    <= ctrl_ff[CW_TCP_BIT]; // RL8
                frame_ff.udp_csum_offload    <= ctrl_ff[CW_UDP_BIT]; // RL9
                frame_ff.ip_csum_offload     <= ctrl_ff[CW_IP_BIT]; // RL10
                frame_ff.crc_append          <= ~ctrl_ff[CW_CRC_INH_BIT] | any_csum; // RL12 RL15
                frame_ff.fragment_total      <= fcount; // RL14
            end
            else if (state_ff == ST_STEP)
                frame_ff.valid <= 1'b0;
            if (mdone && state_ff == ST_DONE_WR)
                desc_count_ff <= desc_count_ff + 32'h1;
            // Except after a fragment high word or the completion write, the next fetch is raised on the clock edge that ends the cycle in which the previous answer lands.
            if (issue && nxt_state != ST_IDLE && nxt_state != ST_FRAG_OUT && nxt_state != ST_STEP)
            begin
                req_ff <= 1'b1;
                wr_ff  <= (nxt_state == ST_DONE_WR);
                unique case (nxt_state)
                    ST_CTRL:    maddr_ff <= entry_addr((state_ff == ST_IDLE) ? head_ff : next_ff, DESC_CTRL_OFS); // RL2
                    ST_NEXT_LO: maddr_ff <= entry_addr(cur_ff, DESC_NEXT_OFS);
                    ST_NEXT_HI: maddr_ff <= entry_addr(cur_ff, DESC_NEXT_OFS + 8'h04);
                    ST_FRAG_LO: maddr_ff <= entry_addr(cur_ff, frag_ofs);
                    ST_FRAG_HI: maddr_ff <= entry_addr(cur_ff, frag_ofs + 8'h04);
                    default:    maddr_ff <= entry_addr(cur_ff, DESC_CTRL_OFS);
                endcase
                mwdata_ff <= ctrl_ff | (32'h1 << CW_OWNER_BIT); // RL13
            end
            else if (mdone)
                req_ff <= 1'b0;
        end
    end

    // ******************************************************************
    // Outputs.
    // ******************************************************************
    assign mreq_o          = '{req: req_ff, wr: wr_ff, addr: maddr_ff, wdata: mwdata_ff};
    assign frame_o         = frame_ff;
    assign frag_valid_o    = fvalid_ff;
    assign crc_force_bad_o = bad_ff;

    // ******************************************************************
    // Checks.
    // ******************************************************************
    owner_skip_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL13
        (state_ff == ST_CTRL && mdone && m_rdata_i[CW_OWNER_BIT]) |=> state_ff == ST_IDLE)
        else $error("Owned descriptor was fetched.");
    chain_end_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL4
        (state_ff == ST_STEP && next_ff == '0) |=> state_ff == ST_IDLE)
        else $error("Chain not ended on zero pointer.");
    crc_forced_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL12
        frame_ff.valid && (frame_ff.tcp_csum_offload || frame_ff.udp_csum_offload || frame_ff.ip_csum_offload)
        |-> frame_ff.crc_append)
        else $error("Offload without CRC append.");
    done_write_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL13
        (req_ff && wr_ff) |-> mwdata_ff[CW_OWNER_BIT])
        else $error("Completion write lacks owner flag.");
    no_frag_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL14
        (state_ff == ST_NEXT_HI && mdone && fcount == 4'h0) |=> state_ff == ST_DONE_WR)
        else $error("Empty descriptor fetched fragments.");
    addr_align_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL2
        (req_ff && !wr_ff && state_ff == ST_CTRL) |-> maddr_ff[2:0] == 3'h0)
        else $error("Control word fetch misaligned.");
    id_copy_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL6
        (state_ff == ST_NEXT_HI && mdone) |=> frame_ff.frame_id == $past(ctrl_ff[15:0]))
        else $error("Frame identifier not captured.");
    step_order_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL16
        (state_ff == ST_STEP && next_ff != '0) |=> cur_ff == $past(next_ff))
        else $error("Chain step went elsewhere.");
    ptr_high_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL3
        (state_ff == ST_NEXT_HI && mdone) |=> next_ff[39:32] == $past(m_rdata_i[7:0]))
        else $error("Next pointer high byte not taken.");
    round_copy_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL7
        (state_ff == ST_NEXT_HI && mdone) |=> frame_ff.length_round_select == $past(ctrl_ff[17:16]))
        else $error("Length rounding select not captured.");
    offload_copy_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL8 RL9 RL10
        (state_ff == ST_NEXT_HI && mdone)
        |=> {frame_ff.ip_csum_offload, frame_ff.udp_csum_offload, frame_ff.tcp_csum_offload}
            == $past(ctrl_ff[CW_IP_BIT:CW_TCP_BIT]))
        else $error("Checksum offload bits not captured.");
    crc_inhibit_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL15
        (state_ff == ST_NEXT_HI && mdone && ctrl_ff[CW_CRC_INH_BIT] && !any_csum) |=> !frame_ff.crc_append)
        else $error("Inhibited CRC still appended.");
    bad_crc_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL15
        (tx_underrun_i && frame_ff.valid) |=> bad_ff)
        else $error("Underrun did not force a bad CRC.");
    frag_range_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL14
        (state_ff == ST_FRAG_OUT) |-> (frag_idx_ff != 4'h0 && frag_idx_ff <= fcount))
        else $error("Fragment handed out beyond the count.");
    req_hold_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL16
        (req_ff && !m_ack_i) |=> (req_ff && maddr_ff == $past(maddr_ff)))
        else $error("Memory request dropped before its answer.");
    done_count_a : assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL13
        (state_ff == ST_DONE_WR && mdone) |=> desc_count_ff == $past(desc_count_ff) + 32'h1)
        else $error("Completed descriptor not counted.");
endmodule

// ### test/tdf_mem_model.sv
`timescale 1ns/10ps
// ******************************************************************
// Host memory holding the descriptor chain.
// ******************************************************************
module tdf_mem_model
(
    input  wire logic               clk_sys_i,
    input  wire tdf_pkg::tdf_mreq_t mreq_i,
    output logic                    m_ack_o,
    output logic [31:0]             m_rdata_o,
    output logic                    bad_addr_o
);
    import tdf_pkg::*;
    logic [31:0] mem [0:1023];
    logic [1:0]  wait_ff;
    logic        slow_ff;
    wire  [9:0]  word_idx = mreq_i.addr[11:2];

    initial
    begin
        for (int i = 0; i < 1024; i++) mem[i] = 32'h0000_0000;
        m_ack_o    = 1'b0;
        m_rdata_o  = 32'h0000_0000;
        bad_addr_o = 1'b0;
        wait_ff    = 2'h0;
        slow_ff    = 1'b0;
    end

    // Answers alternate between prompt and slow; data outside an answer keeps toggling.
    always @(posedge clk_sys_i)
    begin
        m_ack_o   <= 1'b0;
        m_rdata_o <= ~m_rdata_o;
        if (mreq_i.req && !m_ack_o)
        begin
            if (mreq_i.addr[39:12] != 28'h0) bad_addr_o <= 1'b1;
            if (wait_ff == 2'h0)
            begin
                m_ack_o   <= 1'b1;
                m_rdata_o <= mem[word_idx];
                if (mreq_i.wr) mem[word_idx] <= mreq_i.wdata;
                slow_ff   <= ~slow_ff;
                wait_ff   <= slow_ff ? 2'h0 : 2'h3;
            end
            else wait_ff <= wait_ff - 2'h1;
        end
    end
endmodule

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench;
    import tdf_pkg::*;
    logic clk_sys_i, reset_n_i, hsel, hwrite, m_ack, underrun, frag_valid, crc_bad, hready, bad_addr, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, m_rdata, frag_len, rd;
    logic [39:0] frag_addr;
    tdf_mreq_t   mreq;
    tdf_frame_t  frame, prev_frame;
    tdf_frame_t  frames [$];
    int          bad_count, comparisons, frag_pulses, bad_seen;

    tdf_fetch uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata), .mreq_o(mreq), .m_ack_i(m_ack), .m_rdata_i(m_rdata),
        .tx_underrun_i(underrun), .frame_o(frame), .frag_addr_o(frag_addr), .frag_len_o(frag_len),
        .frag_valid_o(frag_valid), .crc_force_bad_o(crc_bad));
    tdf_mem_model mem_model (.clk_sys_i(clk_sys_i), .mreq_i(mreq), .m_ack_o(m_ack),
        .m_rdata_o(m_rdata), .bad_addr_o(bad_addr));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // ******************************************************************
    // Monitor of decoded frames, fragment pulses and forced bad CRC.
    // ******************************************************************
    always @(posedge clk_sys_i)
    begin
        if (frame.valid === 1'b1 && frame !== prev_frame) frames.push_back(frame);
        prev_frame <= frame;
        if (frag_valid === 1'b1) frag_pulses++;
        if (crc_bad === 1'b1 && frame.valid === 1'b1) bad_seen++;
    end

    task chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task ahb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= addr;
        hwrite <= wr;
        @(posedge clk_sys_i);
        while (hready !== 1'b1) @(posedge clk_sys_i);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= data;
        @(posedge clk_sys_i);
        while (hready !== 1'b1) @(posedge clk_sys_i);
        rd = hrdata;
    endtask

    task end_of_test;
        $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #1000000;
        bad_count++;
        end_of_test();
    end

    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, underrun} = '0;
        {bad_count, comparisons, frag_pulses, bad_seen} = '0;
        prev_frame = '0;
        reset_n_i  = 1'b0;
        #1;
        // Descriptors on quad word boundaries at 0x100, 0x200 and 0x300.
        // Upper next-pointer bits of the first one hold junk that must be dropped.
        mem_model.mem[10'h040] = 32'h0000_0200;
        mem_model.mem[10'h041] = 32'hfedc_ba00;
        mem_model.mem[10'h042] = 32'h0216_1234;
        mem_model.mem[10'h044] = 32'h0000_1000;
        mem_model.mem[10'h045] = 32'h0020_0011;
        mem_model.mem[10'h046] = 32'h0000_2000;
        mem_model.mem[10'h047] = 32'h0030_0022;
        mem_model.mem[10'h080] = 32'h0000_0300;
        mem_model.mem[10'h082] = 32'h0121_abcd;
        mem_model.mem[10'h084] = 32'h0000_4400;
        mem_model.mem[10'h085] = 32'h0040_005a;
        mem_model.mem[10'h0c2] = 32'h000b_5555;
        repeat (12) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        underrun <= 1'b1;
        ahb(1'b1, REG_HEAD_LO, 32'h0000_0100);
        ahb(1'b1, REG_HEAD_HI, 32'h0000_0000);
        ahb(1'b1, REG_CTRL, 32'h0000_0001);
        ahb(1'b1, REG_STATUS, 32'h0000_0002);
        for (int i = 0; i < 500 && rd !== 32'h3; i++) ahb(1'b0, REG_COUNT, 32'h0);
        chk(rd, 32'h3);
        ahb(1'b0, REG_CUR_LO, 32'h0);
        chk(rd, 32'h300);
        chk(bad_addr, 1'b0);
        chk(hresp, 1'b0);
        chk(frames.size(), 3);
        chk(frames[0], {1'b1, 16'h1234, 2'b10, 1'b1, 1'b0, 1'b1, 1'b1, 4'h2});
        chk(frames[1], {1'b1, 16'habcd, 2'b01, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1});
        chk(frames[2], {1'b1, 16'h5555, 2'b11, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0});
        chk(frag_pulses, 3);
        chk({frag_addr, frag_len[23:0]}, {40'h5a_0000_4400, 24'h40});
        chk(mem_model.mem[10'h042][31], 1'b1);
        chk(mem_model.mem[10'h082][31], 1'b1);
        chk(mem_model.mem[10'h0c2][31], 1'b1);
        chk(bad_seen > 0, 1'b1);
        ahb(1'b0, REG_STATUS, 32'h0);
        chk(rd[0], 1'b0);
        ahb(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
        // A new kick refetches the control word at 0x308, finds the owner flag set and must not process it again.
        ahb(1'b1, REG_STATUS, 32'h0000_0002);
        for (int i = 0; i < 40; i++) ahb(1'b0, REG_COUNT, 32'h0);
        chk(rd, 32'h3);
        chk(frag_pulses, 3);
        end_of_test();
    end
endmodule
